//--- verilog/bus_interface_reset_sequencer.sv
// Purpose: Reset sequencing for a backplane bus interface controller
// Assumes: 100 MHz clock_i, pins asynchronous, one software register (SYSTEM_RESET_CONTROL_REG) written from outside
// Notes: Three-state pins split into in/out/enable; SYSRESET* is open drain
`timescale 1ns/1ps
`default_nettype none
module bus_interface_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned HOLDOFF_COUNT = HOLDOFF_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Reset sources
    input wire logic internal_reset_in_n_i,
    input wire logic system_reset_in_n_i,
    input wire logic sys_controller_i,
    // System reset control register write
    input wire logic system_reset_control_reg_write_i,
    input wire logic [7:0] system_reset_control_reg_data_i,
    // Local bus handshake
    output logic local_bus_request_n_o,
    input wire logic local_bus_grant_n_i,
    // Priority level 0 pin, output side idles high
    input wire logic priority_level0_line_n_i,
    output logic priority_level0_out_o,
    output logic priority_level0_oe_o,
    // Local processor resets
    output logic halt_n_o,
    output logic reset_n_o,
    // Backplane system reset, open drain
    output logic system_reset_out_o,
    output logic system_reset_oe_o,
    // Control of the rest of the device
    output logic outputs_float_o,
    output logic sysclk_enable_o,
    output logic grant_chain_enable_o,
    output logic clear_internal_o,
    output logic clear_fields_internal_o,
    output logic clear_fields_system_o,
    output logic load_defaults_o,
    output logic in_reset_o
);
    typedef enum logic [1:0] {IDLE, WAIT_GRANT, HOLD} state_type;

    state_type state;
    state_type next_state;
    logic [CNT_W-1:0] count;
    logic [1:0] cause;
    logic internal_reset_in_n;
    logic glob_raw;
    logic sysrst;
    logic [SYNC_STAGES+1:0] drive_hist;
    logic glob_seen;
    logic ipl_late;
    logic internal_reset_in_n_n_s;
    logic grant_n_s;
    logic priority_level0_line_n_n_s;
    logic sysrst_n_s;

    // Pins are asynchronous to clock_i
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_internal_reset_in_n (
        .clock_i(clock_i), .srst_i(srst_i),
        .pin_i(internal_reset_in_n_i), .level_o(internal_reset_in_n_n_s));
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_grant (
        .clock_i(clock_i), .srst_i(srst_i),
        .pin_i(local_bus_grant_n_i), .level_o(grant_n_s));
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_priority_level0_line_n (
        .clock_i(clock_i), .srst_i(srst_i),
        .pin_i(priority_level0_line_n_i), .level_o(priority_level0_line_n_n_s));
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_sysrst (
        .clock_i(clock_i), .srst_i(srst_i),
        .pin_i(system_reset_in_n_i), .level_o(sysrst_n_s));

    assign internal_reset_in_n = !internal_reset_in_n_n_s;
    // Pin stays an input while a seen global request is still held
    assign glob_raw = (internal_reset_in_n || glob_seen) && !priority_level0_line_n_n_s;
    // Own drive echoes back through the synchroniser; masked until it clears
    assign sysrst = !sysrst_n_s && !(|drive_hist);
    wire glob_hold = glob_seen && !priority_level0_line_n_n_s;
    wire system_reset_control_reg_hit = system_reset_control_reg_write_i && (system_reset_control_reg_data_i == SYSRESET_CMD);
    wire start = internal_reset_in_n || sysrst || system_reset_control_reg_hit;
    wire granted = !grant_n_s;
    wire grant_done = granted || (count >= CNT_W'(GRANT_CYCLES - 1));
    wire period_end = (state == HOLD) && (count >= CNT_W'(HOLDOFF_COUNT - 1));
    // Global dropped after internal already released ends at once
    wire glob_end = ipl_late && priority_level0_line_n_n_s;
    // Held system reset finishes as soon as released past a period
    wire sys_hold = (cause == CAUSE_SYSTEM) && sysrst;
    wire finish = glob_end || (period_end && !internal_reset_in_n && !sys_hold);
    // Period restarts while the input is held, so a full one follows release
    wire restart = (state == HOLD) && internal_reset_in_n;
    wire freeze = period_end && sys_hold;

    // Priority: global, internal, system
    wire [1:0] next_cause = glob_raw ? CAUSE_GLOBAL :
                            internal_reset_in_n ? CAUSE_INTERNAL :
                            (sysrst || system_reset_control_reg_hit) ? CAUSE_SYSTEM : CAUSE_NONE;

    always_comb begin
        next_state = state;
        unique case (state)
            IDLE: begin
                if (start) begin
                    next_state = WAIT_GRANT;
                end
            end
            WAIT_GRANT: begin
                if (grant_done) begin
                    next_state = HOLD;
                end
            end
            HOLD: begin
                if (finish) begin
                    next_state = IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state <= IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            // Cleared on every new phase or a restarted period
            if (next_state != state || restart) begin
                count <= '0;
            end else if (!freeze) begin
                count <= count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cause <= CAUSE_NONE;
            glob_seen <= 1'b0;
            ipl_late <= 1'b0;
        end else if (state == IDLE && next_state == IDLE) begin
            cause <= CAUSE_NONE;
            glob_seen <= 1'b0;
            ipl_late <= 1'b0;
        end else begin
            // Higher source may take over; never downgrade
            if (next_cause != CAUSE_NONE && (cause == CAUSE_NONE || next_cause == CAUSE_GLOBAL
                    || (next_cause == CAUSE_INTERNAL && cause == CAUSE_SYSTEM))) begin
                cause <= next_cause;
            end
            if (glob_raw) begin
                glob_seen <= 1'b1;
            end
            if (glob_seen && !internal_reset_in_n && !priority_level0_line_n_n_s) begin
                ipl_late <= 1'b1;
            end
        end
    end

    wire active = (next_state == HOLD);
    wire asking = (next_state == WAIT_GRANT);
    // SYSTEM_RESET_CONTROL_REG write of SYSRESET_CMD issues system reset regardless of controller role
    logic issued;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            issued <= 1'b0;
        end else if (next_state == IDLE) begin
            issued <= 1'b0;
        end else if (system_reset_control_reg_hit) begin
            issued <= 1'b1;
        end
    end
    wire drive_sys = active && (issued || system_reset_control_reg_hit ||
                     (sys_controller_i && next_cause != CAUSE_SYSTEM && cause != CAUSE_SYSTEM));

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            local_bus_request_n_o <= 1'b1;
            halt_n_o <= 1'b1;
            reset_n_o <= 1'b1;
            system_reset_out_o <= 1'b0;
            system_reset_oe_o <= 1'b0;
            drive_hist <= '0;
            priority_level0_out_o <= 1'b1;
            priority_level0_oe_o <= 1'b1;
            outputs_float_o <= 1'b0;
            sysclk_enable_o <= 1'b1;
            grant_chain_enable_o <= 1'b1;
            clear_internal_o <= 1'b0;
            clear_fields_internal_o <= 1'b0;
            clear_fields_system_o <= 1'b0;
            load_defaults_o <= 1'b0;
            in_reset_o <= 1'b0;
        end else begin
            local_bus_request_n_o <= !asking;
            halt_n_o <= !active;
            reset_n_o <= !active;
            system_reset_out_o <= 1'b0;
            system_reset_oe_o <= drive_sys;
            drive_hist <= {drive_hist[SYNC_STAGES:0], drive_sys};
            priority_level0_out_o <= 1'b1;
            priority_level0_oe_o <= !(internal_reset_in_n || glob_hold);
            outputs_float_o <= active;
            sysclk_enable_o <= !glob_raw;
            grant_chain_enable_o <= !glob_raw;
            clear_internal_o <= active;
            clear_fields_internal_o <= active && next_cause == CAUSE_INTERNAL;
            clear_fields_system_o <= active && next_cause == CAUSE_SYSTEM;
            load_defaults_o <= glob_raw;
            in_reset_o <= (next_state != IDLE);
        end
    end

    a_grant_bound: assert property (@(posedge clock_i) disable iff (srst_i)
        state == WAIT_GRANT |-> ##[0:110] state != WAIT_GRANT)
        else $error("grant wait exceeded bound");
    a_halt_follows: assert property (@(posedge clock_i) disable iff (srst_i)
        $rose(state == HOLD) |-> !halt_n_o && !reset_n_o)
        else $error("halt and reset not asserted");
    a_request_drop: assert property (@(posedge clock_i) disable iff (srst_i)
        !halt_n_o |-> local_bus_request_n_o)
        else $error("request held during reset");
    a_float_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        !halt_n_o |-> outputs_float_o)
        else $error("outputs not floated");
    a_ipl_input: assert property (@(posedge clock_i) disable iff (srst_i)
        internal_reset_in_n |=> !priority_level0_oe_o)
        else $error("priority pin still driven");
    a_clock_stop: assert property (@(posedge clock_i) disable iff (srst_i)
        glob_raw |=> !sysclk_enable_o && !grant_chain_enable_o)
        else $error("system clock not stopped");
    a_release_idle: assert property (@(posedge clock_i) disable iff (srst_i)
        state == IDLE && $past(state) == HOLD |-> halt_n_o && !system_reset_oe_o)
        else $error("outputs not released");
    a_system_reset_control_reg_start: assert property (@(posedge clock_i) disable iff (srst_i)
        state == IDLE && system_reset_control_reg_hit |=> state == WAIT_GRANT)
        else $error("command did not start reset");
    a_held_restart: assert property (@(posedge clock_i) disable iff (srst_i)
        state == HOLD && internal_reset_in_n && !glob_seen |=> state == HOLD)
        else $error("reset ended while input held");
endmodule
`default_nettype wire

//--- verilog/reset_seq_pkg.sv
// Purpose: Constants for the bus interface reset sequencer
// Assumes: 100 MHz clock_i
// Notes: Times kept in their own units, cycle counts derived here
package reset_seq_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned GRANT_TIMEOUT_NS = 1000;
    localparam int unsigned HOLDOFF_MS = 200;
    // Longest wait rounds down
    localparam int unsigned GRANT_CYCLES = (GRANT_TIMEOUT_NS * CLK_MHZ) / 1000;
    localparam int unsigned HOLDOFF_CYCLES = HOLDOFF_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 25;
    localparam int SYNC_STAGES = 3;
    localparam logic [7:0] SYSRESET_CMD = 8'hF0;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_INTERNAL = 2'h1;
    localparam logic [1:0] CAUSE_GLOBAL = 2'h2;
    localparam logic [1:0] CAUSE_SYSTEM = 2'h3;
endpackage

//--- verilog/pin_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pins
// Assumes: Single clock, synchronous reset
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import reset_seq_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Pin
    input wire logic pin_i,
    output logic level_o
);
    logic [SYNC_STAGES-1:0] stage;
    wire agree = (stage[1] == stage[2]);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            stage <= {SYNC_STAGES{RESET_VALUE}};
            level_o <= RESET_VALUE;
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], pin_i};
            if (agree) begin
                level_o <= stage[2];
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/lb_arbiter_model.sv
// Purpose: Local bus arbiter model facing the reset sequencer
// Assumes: Grant answers a held request after a set delay
// Notes: Silent mode lets the device run into its grant timeout
`timescale 1ns/1ps
`default_nettype none
module lb_arbiter_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Control from the bench
    input wire logic respond_i,
    input wire logic [7:0] delay_i,
    // Local bus handshake
    input wire logic request_n_i,
    output logic grant_n_o
);
    logic [7:0] waited;

    // Grant drops as soon as the request is withdrawn
    always_ff @(posedge clock_i) begin
        if (srst_i || request_n_i) begin
            waited <= 8'h00;
            grant_n_o <= 1'b1;
        end else begin
            waited <= (waited == 8'hFF) ? waited : waited + 8'h01;
            grant_n_o <= !(respond_i && waited >= delay_i);
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Hold-off shortened to 50 cycles
// Notes: Pins modelled as pulled-up wires
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import reset_seq_pkg::*;
    localparam int HOLD = 50;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic ires_n = 1'b1;
    logic sysdrv_n = 1'b1;
    logic ctrl = 1'b1;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic ipldrv_n = 1'b1;
    logic respond = 1'b1;
    logic [7:0] delay = 8'h05;
    wire logic req_n, gnt_n, ipl_out, ipl_oe, halt_n, rst_n, sys_out, sys_oe;
    wire logic flt, clk_en, chain_en, clr, clr_int, clr_sys, defaults, busy;
    wire logic ipl_pin = ipl_oe ? ipl_out : ipldrv_n;
    wire logic sys_n = sysdrv_n & ~(sys_oe & ~sys_out);
    int err_count = 0;
    int checked = 0;
    int n;

    always #5 clock_i = ~clock_i;

    bus_interface_reset_sequencer #(.HOLDOFF_COUNT(HOLD)) u_dut (.clock_i(clock_i),
        .srst_i(srst_i), .internal_reset_in_n_i(ires_n), .system_reset_in_n_i(sys_n),
        .sys_controller_i(ctrl), .system_reset_control_reg_write_i(wr), .system_reset_control_reg_data_i(wdata),
        .local_bus_request_n_o(req_n), .local_bus_grant_n_i(gnt_n),
        .priority_level0_line_n_i(ipl_pin), .priority_level0_out_o(ipl_out),
        .priority_level0_oe_o(ipl_oe), .halt_n_o(halt_n), .reset_n_o(rst_n),
        .system_reset_out_o(sys_out), .system_reset_oe_o(sys_oe), .outputs_float_o(flt),
        .sysclk_enable_o(clk_en), .grant_chain_enable_o(chain_en), .clear_internal_o(clr),
        .clear_fields_internal_o(clr_int), .clear_fields_system_o(clr_sys),
        .load_defaults_o(defaults), .in_reset_o(busy));
    lb_arbiter_model u_arbiter (.clock_i(clock_i), .srst_i(srst_i), .respond_i(respond),
        .delay_i(delay), .request_n_i(req_n), .grant_n_o(gnt_n));

    function automatic logic pick(input int sel);
        case (sel)
            0: return halt_n;
            1: return req_n;
            default: return busy;
        endcase
    endfunction

    task automatic give_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic span(input int lo, input int hi, input string msg);
        checked++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("Error at %0t: %s took %0d cycles", $time, msg, n);
        end
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_for(input int sel, input logic val, input int max);
        n = 0;
        while (pick(sel) !== val && n < max) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (pick(sel) !== val) begin
            err_count++;
            $display("Error at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask

    task automatic hold(input int cycles);
        repeat (cycles) @(posedge clock_i);
    endtask

    task automatic write_system_reset_control_reg(input logic [7:0] v);
        @(posedge clock_i) begin
            wr <= 1'b1;
            wdata <= v;
        end
        @(posedge clock_i) wr <= 1'b0;
    endtask

    task automatic sc_global;
        @(posedge clock_i) ires_n <= 1'b0;
        wait_for(2, 1'b1, 12);
        check(ipl_oe, 1'b0, "level0 pin still driven");
        @(posedge clock_i) ipldrv_n <= 1'b0;
        hold(8);
        #1;
        check(defaults, 1'b1, "defaults not loaded");
        check(clk_en, 1'b0, "system clock still on");
        check(chain_en, 1'b0, "grant chain still on");
        wait_for(0, 1'b0, 130);
        @(posedge clock_i) ires_n <= 1'b1;
        hold(6);
        // Level0 released after the internal reset input ends the reset at once
        @(posedge clock_i) ipldrv_n <= 1'b1;
        wait_for(2, 1'b0, 12);
        check(clk_en, 1'b1, "system clock off");
        check(halt_n, 1'b1, "halt held");
        check(ipl_oe, 1'b1, "level0 pin not driven");
    endtask

    task automatic sc_grant;
        @(posedge clock_i) ires_n <= 1'b0;
        wait_for(1, 1'b0, 10);
        wait_for(0, 1'b0, 20);
        span(5, 16, "grant to halt");
        check(req_n, 1'b1, "request kept");
        check(rst_n, 1'b0, "reset not driven");
        check(flt, 1'b1, "outputs not floated");
        check(sys_oe, 1'b1, "system reset not issued");
        check(clr_int, 1'b1, "internal fields kept");
        check(clr, 1'b1, "circuitry not cleared");
        check(clr_sys, 1'b0, "system fields cleared");
        @(posedge clock_i) ires_n <= 1'b1;
        wait_for(0, 1'b1, HOLD + 20);
        span(HOLD, HOLD + 10, "hold-off after release");
        check(sys_oe, 1'b0, "system reset held");
        check(flt, 1'b0, "outputs still floating");
    endtask

    task automatic sc_timeout;
        @(posedge clock_i) begin
            respond <= 1'b0;
            ctrl <= 1'b0;
            ires_n <= 1'b0;
        end
        wait_for(1, 1'b0, 10);
        wait_for(0, 1'b0, 120);
        span(98, 103, "grant timeout");
        check(sys_oe, 1'b0, "system reset while not controller");
        hold(3 * HOLD);
        #1;
        check(halt_n, 1'b0, "halt ended while input held");
        @(posedge clock_i) begin
            ires_n <= 1'b1;
            respond <= 1'b1;
        end
        wait_for(0, 1'b1, HOLD + 20);
        span(HOLD, HOLD + 10, "hold-off after long hold");
    endtask

    task automatic sc_system_reset_control_reg;
        write_system_reset_control_reg(8'h0F);
        hold(10);
        #1;
        check(busy, 1'b0, "reset from other code");
        write_system_reset_control_reg(8'hF0);
        wait_for(2, 1'b1, 6);
        wait_for(0, 1'b0, 20);
        check(sys_oe, 1'b1, "system reset not issued");
        wait_for(2, 1'b0, HOLD + 150);
    endtask

    task automatic sc_received;
        @(posedge clock_i) sysdrv_n <= 1'b0;
        wait_for(1, 1'b0, 10);
        wait_for(0, 1'b0, 20);
        check(clr_sys, 1'b1, "system fields kept");
        check(clr_int, 1'b0, "internal fields cleared");
        hold(2 * HOLD);
        #1;
        check(busy, 1'b1, "ended under system reset");
        @(posedge clock_i) sysdrv_n <= 1'b1;
        wait_for(2, 1'b0, 10);
    endtask

    initial begin
        hold(20);
        srst_i <= 1'b0;
        hold(5);
        #1;
        check(halt_n, 1'b1, "halt after reset");
        check(ipl_oe, 1'b1, "level0 pin after reset");
        sc_global();
        hold(5);
        sc_grant();
        hold(5);
        sc_timeout();
        hold(5);
        sc_system_reset_control_reg();
        hold(5);
        sc_received();
        hold(5);
        give_verdict();
    end
endmodule
`default_nettype wire
